// ---- inc/pwm_dither_pkg.sv ----
// Purpose: Shared constants and types for the dithered PWM sequencer
// Assumes: 50 MHz core clock, 32768 Hz sub clock sampled as a level
// Notes:   Cycle and edge counts are derived from times and rates below
package pwm_dither_pkg;
    // Core clock rate
    localparam int unsigned CLK_HZ         = 50_000_000;
    // Duty update period, in ns
    localparam int unsigned UPDATE_NS      = 16_000;
    // Update period in core cycles (exact, 800)
    localparam int unsigned UPDATE_CYC     =
        (UPDATE_NS * (CLK_HZ / 1_000_000)) / 1000;
    // Sub clock rate in Hz, ADC trigger rate in tenths of Hz
    localparam int unsigned SUB_CLK_HZ     = 32768;
    localparam int unsigned ADC_RATE_DHZ   = 16384;
    // Sub clock edges per ADC trigger (20)
    localparam int unsigned ADC_DIV        =
        (SUB_CLK_HZ * 10) / ADC_RATE_DHZ;
    // Dither states per pass, results per sum, samples per step
    localparam int unsigned DITHER_STATES  = 16;
    localparam int unsigned SUM_COUNT      = 16;
    localparam int unsigned ADJUST_SAMPLES = 256;
    // Field positions of the 12-bit target code
    localparam int unsigned BASE_LSB       = 4;
    localparam int unsigned FACTOR_W       = 4;
    // Reset values and code ceiling
    localparam logic [11:0] CODE_RESET     = 12'h000;
    localparam logic [3:0]  IDX_RESET      = 4'hF;
    localparam logic [11:0] CODE_MAX       = 12'hFFF;
    // Closed-loop controller states, Gray along the path
    typedef enum logic [1:0] {
        MODE_OPEN   = 2'b00,
        MODE_CLOSED = 2'b01,
        MODE_ADJUST = 2'b11
    } ctl_t;
endpackage

// ---- logic/dither_pattern_rom.sv ----
// Purpose: Adder bit lookup for one dither factor and state index
// Assumes: Index 0 is the first state of a pass
// Notes:   Factors 9 to 15 use the complements of factors 7 down to 1
`timescale 1ns/1ns
`default_nettype none
module dither_pattern_rom
    import pwm_dither_pkg::*;
(
    // Lookup address
    input  wire logic [3:0] factor_in,
    input  wire logic [3:0] index_in,
    // Adder bit for that state
    output logic            adder_out
);
    // Base column for factors 0 to 8, bit n is state n+1
    function automatic logic [15:0] low_column(input logic [3:0] f);
        case (f)
            4'h0:    low_column = 16'h0000;
            4'h1:    low_column = 16'h0001;
            4'h2:    low_column = 16'h0101;
            4'h3:    low_column = 16'h0421;
            4'h4:    low_column = 16'h1111;
            4'h5:    low_column = 16'h1249;
            4'h6:    low_column = 16'h2525;
            4'h7:    low_column = 16'h2A55;
            4'h8:    low_column = 16'h5555;
            default: low_column = 16'h0000;
        endcase
    endfunction

    // Column for any factor; 9..15 mirror 7..1 inverted
    function automatic logic [15:0] column(input logic [3:0] f);
        if (f > 4'h8) begin
            column = ~low_column(4'h0 - f);
        end else begin
            column = low_column(f);
        end
    endfunction

    // Pick the state's bit from the column
    logic [15:0] col;       // Selected column
    always_comb begin
        col       = column(factor_in);
        adder_out = col[index_in];
    end
endmodule
`default_nettype wire

// ---- logic/pwm_dither_sequencer.sv ----
// Purpose: 8-bit PWM with 16-state duty dithering and ADC trim loop
// Assumes: All inputs synchronous to clk_in; ADC results arrive as
//          single-cycle strobes after each trigger
// Notes:   A new code takes effect at the start of the next pass
`timescale 1ns/1ns
`default_nettype none
module pwm_dither_sequencer
    import pwm_dither_pkg::*;
#(
    parameter int unsigned CARRIER_CYC = UPDATE_CYC
)(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // Control
    input  wire logic [11:0] target_in,
    input  wire logic        closed_loop_in,
    // Feedback converter
    input  wire logic        sub_clock_in,
    input  wire logic        adc_done_in,
    input  wire logic [9:0]  adc_data_in,
    output logic             adc_trigger_out,
    // PWM and events
    output logic             pwm_out,
    output logic             update_tick_out,
    output logic             reload_event_out,
    // Status
    output logic [8:0]       duty_out,
    output logic [11:0]      code_out,
    output logic [11:0]      measure_out,
    output logic             measure_valid_out
);
    // Refuse carrier lengths the counter cannot hold, at elaboration
    if (CARRIER_CYC < 2 || CARRIER_CYC > 1023) begin : g_bad_carrier
        $error("CARRIER_CYC out of range");
    end

    localparam logic [9:0] CAR_LAST  = 10'(CARRIER_CYC - 1);
    localparam logic [4:0] SUB_LAST  = 5'(ADC_DIV - 1);
    localparam logic [3:0] SUM_LAST  = 4'(SUM_COUNT - 1);
    localparam logic [7:0] SMP_LAST  = 8'(ADJUST_SAMPLES - 1);
    localparam logic [3:0] IDX_LAST  = 4'(DITHER_STATES - 1);

    // Whole block state
    typedef struct packed {
        logic [9:0]  car_cnt;     // Carrier position
        logic [3:0]  seq_idx;     // Current dither state
        logic [11:0] pass_code;   // Code frozen for this pass
        logic [8:0]  duty;        // Applied duty, 0..256
        logic [9:0]  threshold;   // Compare point in cycles
        logic        pwm;         // Output level
        logic        tick;        // Update pulse
        logic        reload;      // End of pass pulse
        logic [11:0] code;        // Working code
        logic [11:0] target_seen; // Target last taken
        ctl_t        ctl;         // Loop controller state
        logic        sub_prev;    // Sub clock last level
        logic [4:0]  sub_div;     // Sub clock edge count
        logic        adc_trig;    // Trigger pulse
        logic [3:0]  sum_cnt;     // Results in current sum
        logic [13:0] sum;         // Running sum
        logic [11:0] measure;     // Last 12-bit measurement
        logic        meas_valid;  // Measurement pulse
        logic [7:0]  smp_cnt;     // Samples toward a step
    } core_t;

    core_t cur;       // Registered state
    core_t next_cur;  // Next state

    // Duty in 1/256 steps to carrier cycles
    function automatic logic [9:0] to_threshold(input logic [8:0] d);
        logic [19:0] prod;
        prod = 20'(d) * 20'(CARRIER_CYC);
        to_threshold = prod[17:8];
    endfunction

    // One step up or down on the 12-bit code, saturating
    function automatic logic [11:0] step_code(input logic [11:0] c,
                                              input logic up);
        if (up) begin
            step_code = (c == CODE_MAX) ? c : c + 12'h001;
        end else begin
            step_code = (c == CODE_RESET) ? c : c - 12'h001;
        end
    endfunction

    // Lookup address for the state about to start
    logic        wrap;       // Pass ends at this tick
    logic [11:0] sel_code;   // Code for the coming state
    logic [3:0]  next_idx;   // Coming state index
    logic        adder;      // Adder bit for coming state

    assign wrap     = (cur.seq_idx == IDX_LAST);
    assign sel_code = wrap ? cur.code : cur.pass_code;
    assign next_idx = cur.seq_idx + 4'h1;

    // Pattern table
    dither_pattern_rom u_rom (
        .factor_in (sel_code[FACTOR_W-1:0]),
        .index_in  (next_idx),
        .adder_out (adder)
    );

    // Next-state logic
    always_comb begin
        next_cur            = cur;
        next_cur.tick       = 1'b0;
        next_cur.reload     = 1'b0;
        next_cur.adc_trig   = 1'b0;
        next_cur.meas_valid = 1'b0;
        next_cur.sub_prev   = sub_clock_in;

        // Carrier counter and update tick
        if (cur.car_cnt == CAR_LAST) begin
            next_cur.car_cnt = 10'h000;
            next_cur.tick    = 1'b1;
            next_cur.seq_idx = next_idx;
            // Base plus adder bit, up to 256 for full on
            next_cur.duty = 9'(sel_code[11:BASE_LSB]) + 9'(adder);
            next_cur.threshold = to_threshold(next_cur.duty);
            if (wrap) begin
                next_cur.pass_code = cur.code;
                next_cur.reload    = 1'b1;
            end
        end else begin
            next_cur.car_cnt = cur.car_cnt + 10'h001;
        end
        next_cur.pwm = (next_cur.car_cnt < next_cur.threshold);

        // Loop controller
        if (!closed_loop_in) begin
            // Code straight from the target
            next_cur.code        = target_in;
            next_cur.target_seen = target_in;
            next_cur.ctl         = MODE_OPEN;
            next_cur.sub_div     = 5'h00;
            next_cur.sum_cnt     = 4'h0;
            next_cur.sum         = 14'h0000;
            next_cur.smp_cnt     = 8'h00;
        end else begin
            // Sub clock rising edges pace the converter
            if (sub_clock_in && !cur.sub_prev) begin
                if (cur.sub_div == SUB_LAST) begin
                    next_cur.sub_div  = 5'h00;
                    next_cur.adc_trig = 1'b1;
                end else begin
                    next_cur.sub_div = cur.sub_div + 5'h01;
                end
            end
            // Accumulate results in groups
            if (adc_done_in) begin
                if (cur.sum_cnt == SUM_LAST) begin
                    next_cur.measure    = 12'((cur.sum +
                                          14'(adc_data_in)) >> 2);
                    next_cur.meas_valid = 1'b1;
                    next_cur.sum        = 14'h0000;
                end else begin
                    next_cur.sum = cur.sum + 14'(adc_data_in);
                end
                next_cur.sum_cnt = cur.sum_cnt + 4'h1;
                next_cur.smp_cnt = cur.smp_cnt + 8'h01;
            end
            case (cur.ctl)
                MODE_OPEN: begin
                    // Entering closed loop, start from the target
                    next_cur.ctl = MODE_CLOSED;
                end
                MODE_CLOSED: begin
                    // Step after the last sample of a window
                    if (adc_done_in && cur.smp_cnt == SMP_LAST) begin
                        next_cur.ctl = MODE_ADJUST;
                    end
                end
                MODE_ADJUST: begin
                    // Bang-bang trim of the code
                    if (cur.measure < cur.target_seen) begin
                        next_cur.code = step_code(cur.code, 1'b1);
                    end else if (cur.measure > cur.target_seen) begin
                        next_cur.code = step_code(cur.code, 1'b0);
                    end
                    next_cur.ctl = MODE_CLOSED;
                end
                default: begin
                    next_cur.ctl = MODE_CLOSED;
                end
            endcase
            // A new target restarts the loop from the target
            if (target_in != cur.target_seen) begin
                next_cur.target_seen = target_in;
                next_cur.code        = target_in;
                next_cur.ctl         = MODE_CLOSED;
                next_cur.sum_cnt     = 4'h0;
                next_cur.sum         = 14'h0000;
                next_cur.smp_cnt     = 8'h00;
            end
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cur             <= '0;
            cur.seq_idx     <= IDX_RESET;
            cur.code        <= CODE_RESET;
            cur.pass_code   <= CODE_RESET;
            cur.target_seen <= CODE_RESET;
            cur.ctl         <= MODE_OPEN;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs
    assign pwm_out           = cur.pwm;
    assign update_tick_out   = cur.tick;
    assign reload_event_out  = cur.reload;
    assign adc_trigger_out   = cur.adc_trig;
    assign duty_out          = cur.duty;
    assign code_out          = cur.code;
    assign measure_out       = cur.measure;
    assign measure_valid_out = cur.meas_valid;

    // Helper: cycles since the last tick and ticks since reload
    logic [9:0] gap;        // Cycles since tick
    logic       gap_seen;   // A tick has happened
    logic [4:0] tick_cnt;   // Ticks since reload
    logic       rel_seen;   // A reload has happened
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gap      <= 10'h000;
            gap_seen <= 1'b0;
            tick_cnt <= 5'h00;
            rel_seen <= 1'b0;
        end else begin
            gap      <= cur.tick ? 10'h001 : gap + 10'h001;
            gap_seen <= gap_seen | cur.tick;
            if (cur.reload) begin
                tick_cnt <= 5'h00;
                rel_seen <= 1'b1;
            end else if (cur.tick) begin
                tick_cnt <= tick_cnt + 5'h01;
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_tick_period: assert property (
        update_tick_out && gap_seen |-> gap == 10'(CARRIER_CYC))
        else $error("Update tick period wrong");
    a_reload_count: assert property (
        reload_event_out && rel_seen |-> tick_cnt == 5'h0F)
        else $error("Reload not after sixteen updates");
    a_reload_on_tick: assert property (
        reload_event_out |-> update_tick_out && cur.seq_idx == 4'h0)
        else $error("Reload outside pass start");
    a_duty_adder: assert property (
        cur.car_cnt == CAR_LAST |=>
        duty_out == 9'($past(sel_code[11:4])) + 9'($past(adder)))
        else $error("Duty is not base plus adder");
    a_factor_zero: assert property (
        cur.car_cnt == CAR_LAST && sel_code[3:0] == 4'h0 |=>
        duty_out == 9'($past(sel_code[11:4])))
        else $error("Factor zero dithered");
    a_pwm_zero: assert property (
        duty_out == 9'h000 |-> !pwm_out)
        else $error("PWM high at zero duty");
    a_open_follow: assert property (
        !closed_loop_in ##1 !closed_loop_in && $stable(target_in)
        |-> code_out == target_in)
        else $error("Open loop code not target");
    a_trig_closed: assert property (
        adc_trigger_out |-> $past(closed_loop_in))
        else $error("ADC trigger in open loop");
    a_step_size: assert property (
        cur.ctl == MODE_ADJUST && $stable(target_in) |=>
        code_out == $past(code_out) ||
        code_out == $past(code_out) + 12'h001 ||
        code_out == $past(code_out) - 12'h001)
        else $error("Trim step larger than one");

    c_reload:  cover property (reload_event_out);
    c_adjust:  cover property (cur.ctl == MODE_ADJUST);
    c_measure: cover property (measure_valid_out);
endmodule
`default_nettype wire

// ---- tb/adc_filter_model.sv ----
// Purpose: Stand-in for the RC filter and converter on the trim loop
// Assumes: One answer per trigger, always before the next trigger
// Notes:   Sub clock is sped up to one toggle per core cycle
`timescale 1ns/1ns
`default_nettype none
module adc_filter_model (
    // Clock
    input  wire logic       clk_in,
    // Converter control
    input  wire logic       trigger_in,
    input  wire logic [9:0] level_in,
    input  wire logic       slow_in,
    // Converter side
    output logic            sub_clock_out,
    output logic            done_out,
    output logic [9:0]      data_out
);
    int wait_cyc; // Cycles to the answer, negative when idle

    // Drives all outputs on the falling edge, after the bench has looked
    initial begin
        sub_clock_out <= 1'b0;
        done_out      <= 1'b0;
        data_out      <= 10'h000;
        wait_cyc       = -1;
        forever begin
            @(negedge clk_in);
            sub_clock_out <= ~sub_clock_out;
            // One 10-bit result per trigger, prompt or slow
            done_out <= (wait_cyc == 0);
            if (wait_cyc == 0) begin
                data_out <= level_in;
            end else if (done_out) begin
                // Released bus shows inverted junk, not the old result
                data_out <= ~data_out;
            end
            if (wait_cyc >= 0) begin
                wait_cyc--;
            end
            if (trigger_in === 1'b1) begin
                wait_cyc = slow_in ? 6 : 0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/pwm_dither_sequencer_tb_top.sv ----
// Purpose: Self-checking bench for the dithered PWM sequencer
// Assumes: Shortened carrier of 40 cycles, fast sub clock
// Notes:   Open-loop pattern passes first, then trim steps
`timescale 1ns/1ns
`default_nettype none
module pwm_dither_sequencer_tb_top
    import pwm_dither_pkg::*;
;
    localparam int CYC = 40; // Shortened carrier period
    // Design side
    logic        clk_in, rst_b_in, closed_loop_in;
    logic [11:0] target_in, code_out, measure_out;
    logic        sub_clock_in, adc_done_in, adc_trigger_out;
    logic [9:0]  adc_data_in, adc_level;
    logic        pwm_out, update_tick_out, reload_event_out;
    logic [8:0]  duty_out;
    logic        measure_valid_out, slow;
    int          mismatches, comparisons, f, i;
    // Trim cases: target and range of filter levels
    logic [11:0] c_tgt [0:4] = '{12'h80F, 12'h810, 12'h800, 12'hFFF,
                                 12'h000};
    logic [9:0]  c_lo [0:4] = '{10'h000, 10'h205, 10'h200, 10'h000,
                                10'h001};
    logic [9:0]  c_hi [0:4] = '{10'h202, 10'h3FF, 10'h200, 10'h3FF,
                                10'h3FF};

    pwm_dither_sequencer #(.CARRIER_CYC(CYC)) uut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .target_in(target_in),
        .closed_loop_in(closed_loop_in), .sub_clock_in(sub_clock_in),
        .adc_done_in(adc_done_in), .adc_data_in(adc_data_in),
        .adc_trigger_out(adc_trigger_out), .pwm_out(pwm_out),
        .update_tick_out(update_tick_out),
        .reload_event_out(reload_event_out), .duty_out(duty_out),
        .code_out(code_out), .measure_out(measure_out),
        .measure_valid_out(measure_valid_out));

    adc_filter_model adc_model (
        .clk_in(clk_in), .trigger_in(adc_trigger_out),
        .level_in(adc_level), .slow_in(slow),
        .sub_clock_out(sub_clock_in), .done_out(adc_done_in),
        .data_out(adc_data_in));

    // Expected adder column, bit n is state n+1
    function automatic logic [15:0] pat(input logic [3:0] fac);
        logic [15:0] lo [0:8] = '{16'h0000, 16'h0001, 16'h0101,
            16'h0421, 16'h1111, 16'h1249, 16'h2525, 16'h2A55, 16'h5555};
        pat = (fac <= 4'h8) ? lo[fac] : ~lo[16 - int'(fac)];
    endfunction

    // Expected code after one trim step, saturating
    function automatic logic [11:0] step(input logic [11:0] t,
                                         input logic [9:0] l);
        logic [11:0] m;
        m = {l, 2'b00};
        if (m < t && t != CODE_MAX) step = t + 12'h001;
        else if (m > t && t != 12'h000) step = t - 12'h001;
        else step = t;
    endfunction

    // One comparison, counted
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons,
                 mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Bounded waits for a pass start or a converter result
    task automatic wait_sig(input bit rel);
        int n;
        n = 0;
        while ((rel ? reload_event_out : adc_done_in) !== 1'b1) begin
            @(negedge clk_in);
            n++;
            if (n > 40 * CYC) begin
                chk(1'b0, "wait ran out");
                test_done();
            end
        end
    endtask

    // One full open-loop pass at a given target
    task automatic run_pass(input logic [11:0] tgt);
        int k, hi, gap, w;
        logic [8:0] e;
        logic [15:0] p;
        target_in = tgt;
        p = pat(tgt[3:0]);
        repeat (2) @(negedge clk_in);
        wait_sig(1'b1);
        for (k = 0; k < DITHER_STATES; k++) begin
            e = {1'b0, tgt[11:4]} + {8'h00, p[k]};
            w = (int'(e) * CYC) >> 8;
            chk(duty_out === e, "duty value");
            chk(reload_event_out === (k == 0), "reload");
            hi = 0;
            gap = 0;
            // Count high cycles up to the next tick
            do begin
                hi += int'(pwm_out === 1'b1);
                chk(adc_trigger_out === 1'b0, "open trigger");
                @(negedge clk_in);
                gap++;
            end while (update_tick_out !== 1'b1 && gap < 2 * CYC);
            chk(gap == CYC, "tick spacing");
            chk(hi <= w + 1 && hi + 1 >= w, "pwm width");
        end
    endtask

    // One closed-loop step of 256 results
    task automatic trim_case(input int c);
        int n, gap, tot, mv;
        bit seen;
        logic [11:0] e;
        // Differ from the case's target so the loop surely restarts
        target_in = ~c_tgt[c];
        wait_sig(1'b0);
        @(negedge clk_in);
        target_in = c_tgt[c];
        adc_level = c_lo[c] + 10'($urandom_range(0,
                    int'(c_hi[c] - c_lo[c])));
        slow = 1'($urandom);
        e = step(c_tgt[c], adc_level);
        n = 0;
        gap = 0;
        tot = 0;
        mv = 0;
        seen = 0;
        while (n < ADJUST_SAMPLES) begin
            @(negedge clk_in);
            gap++;
            tot++;
            if (adc_trigger_out === 1'b1) begin
                chk(!seen || gap == 40, "trigger spacing");
                seen = 1;
                gap = 0;
            end
            if (measure_valid_out === 1'b1) begin
                mv++;
                chk(measure_out === {adc_level, 2'b00}, "sum");
            end
            if (adc_done_in === 1'b1) n++;
            if (gap > 200 || tot > 50 * ADJUST_SAMPLES) begin
                chk(1'b0, "no trigger");
                test_done();
            end
        end
        chk(mv == ADJUST_SAMPLES / SUM_COUNT, "sum count");
        chk(code_out === c_tgt[c], "early step");
        repeat (2) @(negedge clk_in);
        chk(code_out === e, "trim step");
    endtask

    // Core clock, 20 ns period
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // Main sequence
    initial begin
        rst_b_in = 1'b0;
        target_in = 12'h000;
        closed_loop_in = 1'b0;
        adc_level = 10'h000;
        slow = 1'b0;
        mismatches = 0;
        comparisons = 0;
        void'($urandom(32'h0000_faf5));
        repeat (8) @(negedge clk_in);
        chk(duty_out === 9'h000 && pwm_out === 1'b0, "reset");
        rst_b_in = 1'b1;
        $display("test reset done");
        // Corners: full scale, zero, mid example
        run_pass(12'hFFF);
        run_pass(12'h000);
        run_pass(12'h807);
        // Every factor with a random base
        for (f = 0; f < 16; f++) begin
            run_pass({8'($urandom), 4'(f)});
        end
        $display("test patterns done");
        closed_loop_in = 1'b1;
        for (i = 0; i < 5; i++) begin
            trim_case(i);
        end
        $display("test trim done");
        test_done();
    end
endmodule
`default_nettype wire
